/* File: logic/sec_pkg.sv */
// Constants, opcodes and state encodings shared by the serial EEPROM command logic
package sec_pkg;

  localparam int BYTE_W = 8;
  localparam int ADDR_W = 12;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int MEM_WORDS = 4096;
  localparam int READ_FIFO_DEPTH = 2;

  // Opcodes, most significant bit first on the wire
  localparam logic [7:0] OPC_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OPC_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OPC_STATUS_READ = 8'h05;
  localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OPC_ARRAY_READ = 8'h03;
  localparam logic [7:0] OPC_ARRAY_WRITE = 8'h02;

  // Status register field positions
  localparam int SR_PIN_PROTECT_BIT = 7;
  localparam int SR_GUARD_HI_BIT = 3;
  localparam int SR_GUARD_LO_BIT = 2;
  localparam int SR_WEL_BIT = 1;
  localparam int SR_BUSY_BIT = 0;

  // Values after reset
  localparam logic WEL_RESET = 1'b0;
  localparam logic [1:0] GUARD_RESET = 2'b00;
  localparam logic PIN_PROTECT_RESET = 1'b0;
  localparam logic [4:0] SYNC_RESET = 5'h19;

  // Lower bounds of the guarded ranges
  localparam logic [ADDR_W-1:0] GUARD_QUARTER_BASE = 12'hc00;
  localparam logic [ADDR_W-1:0] GUARD_HALF_BASE = 12'h800;

  // Byte index within a session
  localparam logic [1:0] BYTE_OPCODE = 2'h0;
  localparam logic [1:0] BYTE_ADDR_HI = 2'h1;
  localparam logic [1:0] BYTE_ADDR_LO = 2'h2;
  localparam logic [1:0] BYTE_DATA = 2'h3;

  // Synchroniser lanes
  localparam int SY_CS = 0;
  localparam int SY_SCK = 1;
  localparam int SY_SI = 2;
  localparam int SY_HOLD = 3;
  localparam int SY_WP = 4;
  localparam int SYNC_N = 5;

  // Programming time
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_PROG_NS = 5000000;
  localparam int PROG_CYCLES_DEFAULT = T_PROG_NS / CLK_PERIOD_NS;

  typedef enum logic [7:0] {
    MODE_IDLE = 8'h01,
    MODE_OPCODE = 8'h02,
    MODE_SET_LATCH = 8'h04,
    MODE_CLEAR_LATCH = 8'h08,
    MODE_STATUS_READ = 8'h10,
    MODE_STATUS_WRITE = 8'h20,
    MODE_ARRAY_READ = 8'h40,
    MODE_ARRAY_WRITE = 8'h80
  } sec_mode_type;

endpackage

/* File: logic/sec_top.sv */
// Command decoder, protection and page load logic of the serial EEPROM
module sec_top
  import sec_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEFAULT,
  parameter int FIFO_DEPTH = READ_FIFO_DEPTH,
  parameter int FIFO_WIDTH = BYTE_W
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so,
  output logic so_oe
);

  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CNT_W = (PROG_CYCLES > 1) ? $clog2(PROG_CYCLES) : 1;
  localparam logic [PTR_W:0] FIFO_FULL = (PTR_W + 1)'(FIFO_DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(FIFO_DEPTH - 1);

  typedef struct packed {
    logic [SYNC_N-1:0] sync1;
    logic [SYNC_N-1:0] sync2;
    logic sck_prev;
    logic cs_prev;
    sec_mode_type mode;
    logic [2:0] bit_pos;
    logic [1:0] byte_cnt;
    logic [7:0] shin;
    logic [ADDR_W-1:0] addr;
    logic loaded;
    logic wp_low_seen;
    logic [7:0] pend_sr;
    logic tx_on;
    logic [7:0] shout;
    logic so;
    logic so_oe;
    logic [FIFO_DEPTH-1:0][FIFO_WIDTH-1:0] fifo;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [PTR_W:0] fcount;
    logic write_enable_latch;
    logic [1:0] guard;
    logic pin_protect;
    logic busy;
    logic prog_status;
    logic [CNT_W-1:0] prog_cnt;
    logic [PAGE_BYTES-1:0] pg_valid;
  } sec_state_type;

  sec_state_type st_q;
  sec_state_type st_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [7:0] mem_q [0:MEM_WORDS-1];
  logic [7:0] pg_data_q [0:PAGE_BYTES-1];
  logic pg_we;
  logic [PAGE_W-1:0] pg_col;
  logic [7:0] pg_byte;
  logic mem_commit;
  logic [7:0] mem_rdata;

  function automatic logic in_guard(input logic [ADDR_W-1:0] a, input logic [1:0] g);
    logic r;
    unique case (g)
      2'b00: r = 1'b0;
      2'b01: r = (a >= GUARD_QUARTER_BASE);
      2'b10: r = (a >= GUARD_HALF_BASE);
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
    return (p == PTR_LAST) ? '0 : p + 1'b1;
  endfunction

  function automatic logic [7:0] status_byte(input sec_state_type s);
    logic [7:0] b;
    b = 8'h00;
    b[SR_PIN_PROTECT_BIT] = s.pin_protect;
    b[SR_GUARD_HI_BIT] = s.guard[1];
    b[SR_GUARD_LO_BIT] = s.guard[0];
    b[SR_WEL_BIT] = s.write_enable_latch;
    b[SR_BUSY_BIT] = s.busy;
    return b;
  endfunction

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign mem_rdata = mem_q[st_q.addr];

  always_comb begin
    logic cs_l;
    logic sck_l;
    logic si_l;
    logic hold_l;
    logic wp_l;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;
    logic push;
    logic pop;
    logic [7:0] b;
    logic [7:0] tx_byte;
    cs_l = st_q.sync2[SY_CS];
    sck_l = st_q.sync2[SY_SCK];
    si_l = st_q.sync2[SY_SI];
    hold_l = st_q.sync2[SY_HOLD];
    wp_l = st_q.sync2[SY_WP];
    b = 8'h00;
    tx_byte = 8'h00;
    push = 1'b0;
    pop = 1'b0;
    pg_we = 1'b0;
    pg_col = st_q.addr[PAGE_W-1:0];
    pg_byte = 8'h00;
    mem_commit = 1'b0;
    st_d = st_q;
    st_d.sync1 = {wp_n, hold_n, si, sck, cs_n};
    st_d.sync2 = st_q.sync1;
    st_d.sck_prev = sck_l;
    st_d.cs_prev = cs_l;
    sck_rise = sck_l & ~st_q.sck_prev & ~cs_l & hold_l;
    sck_fall = ~sck_l & st_q.sck_prev & ~cs_l & hold_l;
    cs_rise = cs_l & ~st_q.cs_prev;
    cs_fall = ~cs_l & st_q.cs_prev;

    if (st_q.busy) begin
      if (st_q.prog_cnt == '0) begin
        st_d.busy = 1'b0;
        st_d.write_enable_latch = 1'b0;
        if (st_q.prog_status) begin
          // only bits 7, 3, 2 are taken from the written byte
          st_d.pin_protect = st_q.pend_sr[SR_PIN_PROTECT_BIT];
          st_d.guard = st_q.pend_sr[SR_GUARD_HI_BIT:SR_GUARD_LO_BIT];
        end else begin
          mem_commit = 1'b1;
        end
      end else begin
        st_d.prog_cnt = st_q.prog_cnt - 1'b1;
      end
    end

    if (!cs_l && !wp_l) begin
      st_d.wp_low_seen = 1'b1;
    end

    if (sck_rise) begin
      b = {st_q.shin[6:0], si_l};
      st_d.shin = b;
      st_d.bit_pos = st_q.bit_pos + 1'b1;
      if (st_q.bit_pos == 3'h7) begin
        if (st_q.byte_cnt != BYTE_DATA) begin
          st_d.byte_cnt = st_q.byte_cnt + 1'b1;
        end
        unique case (st_q.mode)
          MODE_OPCODE: begin
            if (st_q.busy) begin
              st_d.mode = (b == OPC_STATUS_READ) ? MODE_STATUS_READ : MODE_IDLE;
            end else begin
              case (b)
                OPC_SET_WRITE_LATCH: st_d.mode = MODE_SET_LATCH;
                OPC_CLEAR_WRITE_LATCH: st_d.mode = MODE_CLEAR_LATCH;
                OPC_STATUS_READ: st_d.mode = MODE_STATUS_READ;
                OPC_STATUS_WRITE: st_d.mode = MODE_STATUS_WRITE;
                OPC_ARRAY_READ: st_d.mode = MODE_ARRAY_READ;
                OPC_ARRAY_WRITE: begin
                  st_d.mode = MODE_ARRAY_WRITE;
                  st_d.pg_valid = '0;
                end
                default: st_d.mode = MODE_IDLE;
              endcase
            end
          end
          MODE_STATUS_WRITE: begin
            if (st_q.byte_cnt == BYTE_ADDR_HI && !st_q.loaded) begin
              st_d.pend_sr = b;
              st_d.loaded = 1'b1;
            end
          end
          MODE_ARRAY_READ, MODE_ARRAY_WRITE: begin
            if (st_q.byte_cnt == BYTE_ADDR_HI) begin
              st_d.addr[ADDR_W-1:8] = b[ADDR_W-9:0];
            end else if (st_q.byte_cnt == BYTE_ADDR_LO) begin
              st_d.addr[7:0] = b;
            end else if (st_q.mode == MODE_ARRAY_WRITE) begin
              pg_we = 1'b1;
              pg_byte = b;
              st_d.pg_valid[st_q.addr[PAGE_W-1:0]] = 1'b1;
              st_d.addr[PAGE_W-1:0] = st_q.addr[PAGE_W-1:0] + 1'b1;
              st_d.loaded = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end

    if (sck_fall) begin
      if ((st_q.mode == MODE_STATUS_READ && st_q.byte_cnt != BYTE_OPCODE) ||
          (st_q.mode == MODE_ARRAY_READ && st_q.byte_cnt == BYTE_DATA)) begin
        if (st_q.bit_pos == 3'h0) begin
          if (st_q.mode == MODE_STATUS_READ) begin
            tx_byte = status_byte(st_q);
          end else if (st_q.fcount != '0) begin
            tx_byte = st_q.fifo[st_q.rptr];
            pop = 1'b1;
          end
          st_d.so = tx_byte[7];
          st_d.shout = {tx_byte[6:0], 1'b0};
          st_d.tx_on = 1'b1;
        end else begin
          st_d.so = st_q.shout[7];
          st_d.shout = {st_q.shout[6:0], 1'b0};
        end
      end
    end

    // prefetch successive bytes, address wraps at top
    if (st_q.mode == MODE_ARRAY_READ && st_q.byte_cnt == BYTE_DATA && (st_q.fcount < FIFO_FULL || pop)) begin
      push = 1'b1;
      st_d.fifo[st_q.wptr] = mem_rdata;
      st_d.wptr = ptr_next(st_q.wptr);
      st_d.addr = st_q.addr + 1'b1;
    end
    if (pop) begin
      st_d.rptr = ptr_next(st_q.rptr);
    end
    if (push && !pop) begin
      st_d.fcount = st_q.fcount + 1'b1;
    end else if (pop && !push) begin
      st_d.fcount = st_q.fcount - 1'b1;
    end

    if (cs_fall) begin
      st_d.mode = MODE_OPCODE;
      st_d.bit_pos = 3'h0;
      st_d.byte_cnt = BYTE_OPCODE;
      st_d.loaded = 1'b0;
      st_d.wp_low_seen = ~wp_l;
      st_d.tx_on = 1'b0;
    end

    if (cs_rise) begin
      if (st_q.bit_pos == 3'h0) begin
        unique case (st_q.mode)
          MODE_SET_LATCH: st_d.write_enable_latch = (st_q.byte_cnt == BYTE_ADDR_HI) ? 1'b1 : st_q.write_enable_latch;
          MODE_CLEAR_LATCH: st_d.write_enable_latch = (st_q.byte_cnt == BYTE_ADDR_HI) ? 1'b0 : st_q.write_enable_latch;
          MODE_STATUS_WRITE: begin
            // latch plus pin check for status
            // pin low at any time in the session aborts when pin protect is set
            if (st_q.write_enable_latch && st_q.loaded && !(st_q.pin_protect && st_q.wp_low_seen)) begin
              st_d.busy = 1'b1;
              st_d.prog_status = 1'b1;
              st_d.prog_cnt = CNT_W'(PROG_CYCLES - 1);
            end
          end
          MODE_ARRAY_WRITE: begin
            // latch set and page not guarded
            if (st_q.write_enable_latch && st_q.loaded && !in_guard(st_q.addr, st_q.guard)) begin
              st_d.busy = 1'b1;
              st_d.prog_status = 1'b0;
              st_d.prog_cnt = CNT_W'(PROG_CYCLES - 1);
            end
          end
          default: begin
          end
        endcase
      end
      st_d.mode = MODE_IDLE;
      st_d.tx_on = 1'b0;
    end

    if (cs_rise || cs_fall) begin
      st_d.wptr = '0;
      st_d.rptr = '0;
      st_d.fcount = '0;
    end

    st_d.so_oe = st_d.tx_on & ~cs_l & hold_l;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.sync1 <= SYNC_RESET;
      st_q.sync2 <= SYNC_RESET;
      st_q.sck_prev <= 1'b0;
      st_q.cs_prev <= 1'b1;
      st_q.mode <= MODE_IDLE;
      st_q.write_enable_latch <= WEL_RESET;
      st_q.guard <= GUARD_RESET;
      st_q.pin_protect <= PIN_PROTECT_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Page buffer and cell array hold no reset; contents are data, not control
  always_ff @(posedge mclk) begin
    if (pg_we) begin
      pg_data_q[pg_col] <= pg_byte;
    end
  end

  always_ff @(posedge mclk) begin
    if (mem_commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (st_q.pg_valid[i]) begin
          mem_q[{st_q.addr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= pg_data_q[i];
        end
      end
    end
  end

  assign so = st_q.so;
  assign so_oe = st_q.so_oe;

endmodule // sec_top

/* File: testbench/sec_asserts.sv */
// Port assertions for the serial EEPROM command block
module sec_asserts
  import sec_pkg::*;
#(
  parameter int PROG_CYCLES = 50
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so,
  input wire logic so_oe
);
  logic quiet;
  logic [5:0] qh_q;
  assign quiet = cs_n || !hold_n;
  // Pin-to-port lag is a few cycles, so keep a short history
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      qh_q <= 6'h3f;
    end else begin
      qh_q <= {qh_q[4:0], quiet};
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  reset_quiet_a: assert property ($rose(reset_n) |-> !so_oe ##1 !so_oe)
    else $error("output enabled after reset");
  oe_idle_cs_a: assert property (cs_n [*6] |-> !so_oe)
    else $error("output enabled while deselected");
  oe_hold_off_a: assert property (!hold_n [*6] |-> !so_oe)
    else $error("output enabled during pause");
  oe_start_sel_a: assert property ($rose(so_oe) |-> !cs_n && hold_n)
    else $error("output enabled outside a session");
  oe_rise_fall_a: assert property ($rose(so_oe) |-> !$past(sck, 3))
    else $error("output enabled not after a falling clock");
  so_fall_edge_a: assert property (so_oe && $changed(so) |-> !$past(sck, 2) || $past(quiet, 2))
    else $error("output bit moved away from falling clock");
  so_hold_bit_a: assert property (so_oe && $changed(so) |=> (!so_oe || $stable(so)) [*3])
    else $error("output bit not held");
  oe_drop_cause_a: assert property ($fell(so_oe) |-> |qh_q)
    else $error("output disabled without deselect or pause");
  cover property ($rose(so_oe));
  cover property (!hold_n && !cs_n && $changed(si));
  cover property (!wp_n && !cs_n);
  cover property ($fell(so_oe) && cs_n);
endmodule // sec_asserts

bind sec_top sec_asserts #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.mclk(mclk), .reset_n(reset_n), .cs_n(cs_n),
  .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe));

/* File: testbench/sec_host.sv */
// Host serial master model: chip select, clock, data and pause
module sec_host (
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 100ps;
  logic mode3;
  initial begin
    mode3 = 1'b0;
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task automatic open_s();
    sck = mode3;
    #40;
    cs_n = 1'b0;
    #40;
  endtask
  task automatic close_s();
    sck = mode3;
    #64;
    cs_n = 1'b1;
    si = ~si;
    #80;
  endtask
  // Sample just before the fall, where the bit is surely settled
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si = d[i];
      #32;
      sck = 1'b1;
      #31;
      q[i] = so;
      #1;
    end
  endtask
  task automatic pause(input int n);
    sck = 1'b0;
    #32;
    hold_n = 1'b0;
    repeat (n) begin
      si = ~si;
      #64;
    end
    hold_n = 1'b1;
    #32;
  endtask
endmodule // sec_host

/* File: testbench/sec_top_tb.sv */
// Self-checking bench for the serial EEPROM command block
module sec_top_tb
  import sec_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, reset_n, wp_n, so, so_oe, cs_n, sck, si, hold_n, oe_seen;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed;
  logic [7:0] mem_m [0:4095];
  logic [7:0] st, rb, op;
  logic [5:0] sr_m;
  logic [11:0] edg [6] = '{12'h000, 12'h7ff, 12'h800, 12'hbff, 12'hc00, 12'hfff};
  sec_top #(.PROG_CYCLES(600)) dut_u (.mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe));
  // A released output reads inverted, so a bit taken while disabled shows up as a mismatch
  sec_host host_u (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so(so_oe ? so : ~so));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (so_oe === 1'b1)
      oe_seen = 1'b1;
    if (cycles == 80000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic prot(input logic [11:0] a);
    case (sr_m[1:0])
      2'b01: return a >= 12'hc00;
      2'b10: return a >= 12'h800;
      2'b11: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic one(input logic [7:0] o);
    host_u.open_s();
    host_u.xbyte(o, rb);
    host_u.close_s();
  endtask
  task automatic status_read_cmd();
    host_u.open_s();
    host_u.xbyte(OPC_STATUS_READ, rb);
    host_u.xbyte(8'($random(seed)), st);
    host_u.close_s();
  endtask
  task automatic settle();
    status_read_cmd();
    for (int i = 0; i < 20 && st[SR_BUSY_BIT] !== 1'b0; i++)
      status_read_cmd();
  endtask
  // A read or clear sent while busy must be ignored; otherwise the clear drops the latch
  task automatic finish_wr(input logic ok);
    host_u.close_s();
    if (ok) begin
      oe_seen = 1'b0;
      host_u.open_s();
      host_u.xbyte(OPC_ARRAY_READ, rb);
      host_u.xbyte(8'($random(seed)), rb);
      host_u.xbyte(8'($random(seed)), rb);
      host_u.close_s();
      chk({7'h0, oe_seen}, 8'h00);
    end
    one(OPC_CLEAR_WRITE_LATCH);
    status_read_cmd();
    chk(st, {sr_m, ok, ok});
    settle();
  endtask
  task automatic wr(input logic [11:0] a, input int n, input logic en);
    logic [7:0] d;
    logic ok;
    ok = en && !prot(a);
    if (en)
      one(OPC_SET_WRITE_LATCH);
    host_u.open_s();
    host_u.xbyte(OPC_ARRAY_WRITE, rb);
    host_u.xbyte({4'($random(seed)), a[11:8]}, rb);
    host_u.xbyte(a[7:0], rb);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      host_u.xbyte(d, rb);
      if (ok)
        mem_m[{a[11:5], 5'(a[4:0] + i)}] = d;
    end
    finish_wr(ok);
    chk(st, {sr_m, 2'b00});
  endtask
  task automatic rd(input logic [11:0] a, input int n, input int hold_at);
    host_u.open_s();
    host_u.xbyte(OPC_ARRAY_READ, rb);
    host_u.xbyte({4'($random(seed)), a[11:8]}, rb);
    host_u.xbyte(a[7:0], rb);
    for (int i = 0; i < n; i++) begin
      if (i == hold_at)
        host_u.pause(4);
      host_u.xbyte(8'($random(seed)), rb);
      chk(rb, mem_m[12'(a + i)]);
    end
    host_u.close_s();
  endtask
  task automatic status_write_cmd(input logic [7:0] v, input logic drop);
    logic ok;
    ok = (!sr_m[5] || wp_n) && !(drop && sr_m[5]);
    one(OPC_SET_WRITE_LATCH);
    host_u.open_s();
    host_u.xbyte(OPC_STATUS_WRITE, rb);
    host_u.xbyte(v, rb);
    if (drop) begin
      @(negedge mclk);
      wp_n = 1'b0;
    end
    finish_wr(ok);
    chk(st, {(ok ? {v[7], 3'b000, v[3:2]} : sr_m), 2'b00});
    if (ok)
      sr_m = {v[7], 3'b000, v[3:2]};
    chk(st, {sr_m, 2'b00});
  endtask
  initial begin
    seed = 32'h41ad;
    reset_n = 1'b0;
    wp_n = 1'b1;
    sr_m = 6'h00;
    oe_seen = 1'b0;
    repeat (12) @(negedge mclk);
    reset_n = 1'b1;
    repeat (8) @(negedge mclk);
    host_u.mode3 = 1'b1;
    status_read_cmd();
    chk(st, 8'h00);
    host_u.mode3 = 1'b0;
    one(OPC_SET_WRITE_LATCH);
    status_read_cmd();
    chk(st, 8'h02);
    oe_seen = 1'b0;
    for (int i = 0; i < 6; i++) begin
      op = i == 0 ? 8'h00 : i == 1 ? 8'h07 : 8'($random(seed)) | 8'h08;
      host_u.open_s();
      host_u.xbyte(op, rb);
      host_u.xbyte(8'($random(seed)), rb);
      host_u.close_s();
    end
    chk({7'h0, oe_seen}, 8'h00);
    status_read_cmd();
    chk(st, 8'h02);
    one(OPC_CLEAR_WRITE_LATCH);
    status_read_cmd();
    chk(st, 8'h00);
    $display("Test commands done");
    for (int i = 0; i < 6; i++)
      wr(edg[i], 1, 1'b1);
    wr(12'h000, 1, 1'b0);
    rd(12'h000, 1, -1);
    for (int b = 1; b < 4; b++) begin
      status_write_cmd({1'b0, 3'($random(seed)), 2'(b), 2'($random(seed))}, 1'b0);
      for (int i = 0; i < 6; i++) begin
        wr(edg[i], 1, 1'b1);
        rd(edg[i], 1, -1);
      end
    end
    status_write_cmd(8'h80, 1'b0);
    @(negedge mclk);
    wp_n = 1'b0;
    status_write_cmd(8'h8c, 1'b0);
    wr(12'h000, 1, 1'b1);
    @(negedge mclk);
    wp_n = 1'b1;
    status_write_cmd(8'h84, 1'b1);
    @(negedge mclk);
    wp_n = 1'b1;
    status_write_cmd(8'h00, 1'b0);
    $display("Test protection done");
    wr(12'h3de, 34, 1'b1);
    rd(12'h3c0, 32, 5);
    host_u.mode3 = 1'b1;
    rd(12'hfff, 2, -1);
    one(OPC_SET_WRITE_LATCH);
    @(negedge mclk);
    reset_n = 1'b0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    repeat (8) @(negedge mclk);
    status_read_cmd();
    chk(st, 8'h00);
    $display("Test page and read done");
    end_sim();
  end
endmodule // sec_top_tb
